/* File: hdl/slc_list_regs.sv */
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module slc_list_regs #(
    parameter int unsigned HALF_MS_CYC = slc_pkg::DWELL_UNIT_NS / slc_pkg::CLK_PERIOD_NS
) (
    input  wire logic        clock,           // system clock
    input  wire logic        rstn,            // async reset
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    input  wire logic        extTrig,         // front trigger input
    input  wire logic [7:0]  bpTrig,          // backplane trigger lines
    input  wire logic        backplaneFitted, // backplane variant strap
    output logic      [39:0] outFreq,         // output frequency, mHz
    output logic      [15:0] outLevel,        // output level
    output logic             sweepActive      // list engine running
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
        hit = (a[7:2] == idx);
    endfunction

    function automatic logic [11:0] clampLen(input logic [31:0] v);
        clampLen = (v > {20'h00000, slc_pkg::BUF_DEPTH}) ? slc_pkg::BUF_DEPTH : v[11:0];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0]               repeatCount_r;
    slc_pkg::slc_trig_cfg_t    trigCfg_r;
    logic [31:0]               pointTotal_r;
    logic [15:0]               loadHi_r;
    logic [7:0]                freqHi_r;
    logic                      stepMode_r;
    logic                      waitReq_r;
    logic [31:0]               readData_r;
    logic                      loadActive_r;
    logic [1:0]                expTag_r;
    logic [11:0]               loadIdx_r;
    logic [45:0]               stFreq_r;
    logic [15:0]               stLevel_r;
    logic                      copyBusy_r;
    logic                      copyDir_r;
    logic [11:0]               copyIdx_r;
    logic [11:0]               copyLen_r;
    logic [11:0]               nvCount_r;
    slc_pkg::slc_state_t       state_r;
    logic [10:0]               ptIdx_r;
    logic [31:0]               cycles_r;
    logic [31:0]               dwellLeft_r;
    logic [31:0]               preCnt_r;
    logic                      trigPrev_r;
    logic [39:0]               outFreq_r;
    logic [15:0]               outLevel_r;
    logic                      sweepActive_r;
    slc_pkg::slc_point_t       bufMem [0:slc_pkg::BUF_ENTRIES-1];
    slc_pkg::slc_point_t       nvMem  [0:slc_pkg::BUF_ENTRIES-1];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire        req        = avs_read | avs_write;
    wire        waitReq_nxt = ~(req & waitReq_r & ~copyBusy_r);
    wire        wrEn       = avs_write & ~waitReq_r;
    wire        loaderWr   = wrEn & hit(avs_address, slc_pkg::IDX_LOAD_LO);
    wire        totalWr    = wrEn & hit(avs_address, slc_pkg::IDX_TOTAL);
    wire        copyWr     = wrEn & hit(avs_address, slc_pkg::IDX_COPY);
    wire        freqWr     = wrEn & hit(avs_address, slc_pkg::IDX_FREQ_LO);
    wire        swKick     = wrEn & hit(avs_address, slc_pkg::IDX_KICK);
    wire [31:0] statusWord = {sweepActive_r, loadActive_r, copyBusy_r, 1'b0, loadIdx_r, 5'h00, ptIdx_r};
    wire [31:0] readData_nxt =
        hit(avs_address, slc_pkg::IDX_STATUS) ? statusWord :
        hit(avs_address, slc_pkg::IDX_CTRL)   ? {31'h00000000, stepMode_r} : 32'h00000000;

    // ----------------------------------------------------------------
    // point loader
    // ----------------------------------------------------------------
    wire [47:0] loaderWord = {loadHi_r, avs_writedata};
    wire        isStart    = (loaderWord == slc_pkg::LOADER_START);
    wire        isEnd      = (loaderWord == slc_pkg::LOADER_END);
    wire [1:0]  wordTag    = loaderWord[47:46];
    wire        tagOk      = loadActive_r & ~isStart & ~isEnd & (wordTag == expTag_r);
    wire        bufFull    = (loadIdx_r >= slc_pkg::BUF_DEPTH);
    wire        setDone    = loaderWr & tagOk & (expTag_r == slc_pkg::TAG_DWELL) & ~bufFull;
    wire [1:0]  expTag_nxt = (expTag_r == slc_pkg::TAG_FREQ)  ? slc_pkg::TAG_LEVEL :
                             (expTag_r == slc_pkg::TAG_LEVEL) ? slc_pkg::TAG_DWELL : slc_pkg::TAG_FREQ;
    wire slc_pkg::slc_point_t loadPoint = '{freq: stFreq_r, level: stLevel_r,
                                           dwell: loaderWord[31:0]};

    // ----------------------------------------------------------------
    // storage copy
    // ----------------------------------------------------------------
    wire [11:0] storeLen  = clampLen(pointTotal_r);
    wire [11:0] copyLenIn = avs_writedata[slc_pkg::COPY_DIR_BIT] ? nvCount_r : storeLen;
    wire        copyStart = copyWr & (copyLenIn != 12'h000);
    wire        copyLast  = copyBusy_r & (copyIdx_r == copyLen_r - 12'h001);
    wire        bufWe     = setDone | (copyBusy_r & copyDir_r);
    wire [10:0] bufWAddr  = copyBusy_r ? copyIdx_r[10:0] : loadIdx_r[10:0];
    wire slc_pkg::slc_point_t bufWData = copyBusy_r ? nvMem[copyIdx_r[10:0]] : loadPoint;

    // ----------------------------------------------------------------
    // trigger select and edge
    // ----------------------------------------------------------------
    wire trigIn = (trigCfg_r.bpEnable & backplaneFitted) ? bpTrig[trigCfg_r.line] : extTrig;
    wire hwEdge = trigCfg_r.risingEdge ? (trigIn & ~trigPrev_r) : (~trigIn & trigPrev_r);
    wire anyTrig = hwEdge | swKick;

    // ----------------------------------------------------------------
    // list engine
    // ----------------------------------------------------------------
    wire [11:0] listLen  = clampLen(pointTotal_r);
    wire        running  = (state_r == slc_pkg::ST_RUN);
    wire        tick     = (preCnt_r == 32'(HALF_MS_CYC - 1));
    wire        startEv  = ~running & (stepMode_r ? hwEdge : anyTrig) & (listLen != 12'h000);
    wire        stopEv   = running & (stepMode_r ? swKick : anyTrig);
    wire        advEv    = running & ~stopEv &
                           (stepMode_r ? hwEdge : (tick & (dwellLeft_r <= 32'h00000001)));
    wire        lastPt   = ({1'b0, ptIdx_r} == listLen - 12'h001);
    wire [31:0] cycNext  = cycles_r + 32'h00000001;
    wire        finish   = advEv & lastPt & (repeatCount_r != 32'h00000000) &
                           (cycNext == repeatCount_r);
    wire        loadPt   = startEv | (advEv & ~finish);
    wire [10:0] nextIdx  = (startEv | lastPt) ? 11'h000 : ptIdx_r + 11'h001;
    wire slc_pkg::slc_point_t nextPt = bufMem[nextIdx];
    wire slc_pkg::slc_state_t state_nxt =
        startEv ? slc_pkg::ST_RUN : ((stopEv | finish) ? slc_pkg::ST_IDLE : state_r);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            waitReq_r  <= 1'b1;
            readData_r <= 32'h00000000;
        end else begin
            waitReq_r  <= waitReq_nxt;
            readData_r <= readData_nxt;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            repeatCount_r <= 32'h00000000;
            trigCfg_r     <= '0;
            loadHi_r      <= 16'h0000;
            freqHi_r      <= 8'h00;
            stepMode_r    <= 1'b0;
        end else if (wrEn) begin
            if (hit(avs_address, slc_pkg::IDX_REPEAT))  repeatCount_r <= avs_writedata;
            if (hit(avs_address, slc_pkg::IDX_TRIG))    trigCfg_r     <= avs_writedata[4:0];
            if (hit(avs_address, slc_pkg::IDX_LOAD_HI)) loadHi_r      <= avs_writedata[15:0];
            if (hit(avs_address, slc_pkg::IDX_FREQ_HI)) freqHi_r      <= avs_writedata[7:0];
            if (hit(avs_address, slc_pkg::IDX_CTRL))    stepMode_r    <= avs_writedata[slc_pkg::CTRL_STEP_BIT];
        end
    end

    // point total: register write beats loader end and restore
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pointTotal_r <= 32'h00000000;
        end else if (totalWr) begin
            pointTotal_r <= avs_writedata;
        end else if (loaderWr & isEnd & loadActive_r) begin
            pointTotal_r <= {20'h00000, loadIdx_r};
        end else if (copyLast & copyDir_r) begin
            pointTotal_r <= {20'h00000, copyLen_r};
        end
    end

    // ----------------------------------------------------------------
    // loader sequence
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loadActive_r <= 1'b0;
            expTag_r     <= slc_pkg::TAG_FREQ;
            loadIdx_r    <= 12'h000;
            stFreq_r     <= 46'h0;
            stLevel_r    <= 16'h0000;
        end else if (loaderWr) begin
            if (isStart) begin
                loadActive_r <= 1'b1;
                expTag_r     <= slc_pkg::TAG_FREQ;
                loadIdx_r    <= 12'h000;
            end else if (isEnd) begin
                loadActive_r <= 1'b0;
            end else if (tagOk) begin
                expTag_r <= expTag_nxt;
                if (expTag_r == slc_pkg::TAG_FREQ)  stFreq_r  <= loaderWord[45:0];
                if (expTag_r == slc_pkg::TAG_LEVEL) stLevel_r <= loaderWord[15:0];
                if (setDone)                        loadIdx_r <= loadIdx_r + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // storage copy sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            copyBusy_r <= 1'b0;
            copyDir_r  <= 1'b0;
            copyIdx_r  <= 12'h000;
            copyLen_r  <= 12'h000;
            nvCount_r  <= 12'h000;
        end else if (copyStart) begin
            copyBusy_r <= 1'b1;
            copyDir_r  <= avs_writedata[slc_pkg::COPY_DIR_BIT];
            copyIdx_r  <= 12'h000;
            copyLen_r  <= copyLenIn;
        end else if (copyBusy_r) begin
            copyIdx_r <= copyIdx_r + 12'h001;
            if (copyLast) begin
                copyBusy_r <= 1'b0;
                if (!copyDir_r) nvCount_r <= copyLen_r;
            end
        end
    end

    // buffers hold no reset
    always_ff @(posedge clock) begin
        if (bufWe) bufMem[bufWAddr] <= bufWData;
        if (copyBusy_r & ~copyDir_r) nvMem[copyIdx_r[10:0]] <= bufMem[copyIdx_r[10:0]];
    end

    // ----------------------------------------------------------------
    // list engine registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r     <= slc_pkg::ST_IDLE;
            ptIdx_r     <= 11'h000;
            cycles_r    <= 32'h00000000;
            dwellLeft_r <= 32'h00000000;
            preCnt_r    <= 32'h00000000;
            trigPrev_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            trigPrev_r <= trigIn;
            if (startEv)             cycles_r <= 32'h00000000;
            else if (advEv & lastPt) cycles_r <= cycNext;
            if (loadPt) begin
                ptIdx_r     <= nextIdx;
                dwellLeft_r <= nextPt.dwell;
                preCnt_r    <= 32'h00000000;
            end else if (running) begin
                preCnt_r <= tick ? 32'h00000000 : preCnt_r + 32'h00000001;
                if (tick) dwellLeft_r <= dwellLeft_r - 32'h00000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            outFreq_r     <= 40'h0;
            outLevel_r    <= 16'h0000;
            sweepActive_r <= 1'b0;
        end else begin
            sweepActive_r <= (state_nxt == slc_pkg::ST_RUN);
            if (freqWr)      outFreq_r <= {freqHi_r, avs_writedata};
            else if (loadPt) outFreq_r <= nextPt.freq[39:0];
            if (loadPt)      outLevel_r <= nextPt.level;
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata    = readData_r;
    assign outFreq         = outFreq_r;
    assign outLevel        = outLevel_r;
    assign sweepActive     = sweepActive_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence loadFullSet;
        loaderWr && tagOk && expTag_r == slc_pkg::TAG_DWELL && !bufFull;
    endsequence

    forever_run_a: assert property (
        (running && repeatCount_r == 32'h00000000 && !stopEv) |=> running)
        else $error("sweep stopped with zero repeat count");
    cycle_limit_a: assert property (
        finish |=> !running && cycles_r == repeatCount_r)
        else $error("sweep did not stop at repeat count");
    trig_edge_a: assert property (
        hwEdge |-> trigIn == trigCfg_r.risingEdge && $past(trigIn) != trigIn)
        else $error("trigger edge polarity wrong");
    bp_line_a: assert property (
        (trigCfg_r.bpEnable && backplaneFitted) |-> trigIn == bpTrig[trigCfg_r.line])
        else $error("backplane line not selected");
    bp_absent_a: assert property (
        !backplaneFitted |-> trigIn == extTrig)
        else $error("backplane used on plain variant");
    idx_bound_a: assert property (
        running |-> {1'b0, ptIdx_r} < listLen)
        else $error("list index past point total");
    total_write_a: assert property (
        totalWr |=> pointTotal_r == $past(avs_writedata))
        else $error("point total write not applied");
    set_store_a: assert property (
        loadFullSet |=> loadIdx_r == $past(loadIdx_r) + 12'h001)
        else $error("full set did not advance index");
    load_start_a: assert property (
        (loaderWr && isStart) |=> loadActive_r && loadIdx_r == 12'h000 && expTag_r == slc_pkg::TAG_FREQ)
        else $error("start word did not reset loader");
    load_end_a: assert property (
        (loaderWr && isEnd && loadActive_r && !totalWr) |=>
            !loadActive_r && pointTotal_r == {20'h00000, $past(loadIdx_r)})
        else $error("end word did not record set count");
    bad_tag_a: assert property (
        (loaderWr && !isStart && !isEnd && !tagOk) |=> $stable(loadIdx_r) && $stable(expTag_r))
        else $error("out-of-order word changed loader");
    store_len_a: assert property (
        (copyStart && !avs_writedata[slc_pkg::COPY_DIR_BIT]) |=> copyBusy_r && !copyDir_r && copyLen_r == $past(storeLen))
        else $error("store copy length wrong");
    restore_a: assert property (
        (copyStart && avs_writedata[slc_pkg::COPY_DIR_BIT]) |=> copyBusy_r && copyDir_r && copyLen_r == $past(nvCount_r))
        else $error("restore copy not started");
    kick_stop_a: assert property (
        (running && stepMode_r && swKick) |=> !running && !sweepActive_r)
        else $error("kick did not stop stepping");
    out_freq_a: assert property (
        freqWr |=> outFreq_r == {$past(freqHi_r), $past(avs_writedata)})
        else $error("output frequency word not loaded");
    step_adv_a: assert property (
        (running && stepMode_r && hwEdge && !lastPt && !swKick) |=> ptIdx_r == $past(ptIdx_r) + 11'h001)
        else $error("trigger did not step list");
    dwell_unit_a: assert property (
        running |-> preCnt_r < 32'(HALF_MS_CYC))
        else $error("dwell prescaler overran");

endmodule

/* File: hdl/slc_pkg.sv */
package slc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DWELL_UNIT_NS = 500000;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_REPEAT  = 6'h0A;
    localparam logic [5:0] IDX_TRIG    = 6'h0B;
    localparam logic [5:0] IDX_TOTAL   = 6'h0C;
    localparam logic [5:0] IDX_LOAD_LO = 6'h0D;
    localparam logic [5:0] IDX_COPY    = 6'h0E;
    localparam logic [5:0] IDX_KICK    = 6'h0F;
    localparam logic [5:0] IDX_FREQ_LO = 6'h10;
    localparam logic [5:0] IDX_LOAD_HI = 6'h20;
    localparam logic [5:0] IDX_FREQ_HI = 6'h21;
    localparam logic [5:0] IDX_CTRL    = 6'h22;
    localparam logic [5:0] IDX_STATUS  = 6'h23;

    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int          BUF_ENTRIES  = 2048;
    localparam logic [11:0] BUF_DEPTH    = 12'h800;
    localparam logic [47:0] LOADER_START = 48'h0000_0000_0000;
    localparam logic [47:0] LOADER_END   = 48'hFFFF_FFFF_FFFF;
    localparam logic [1:0]  TAG_FREQ     = 2'h0;
    localparam logic [1:0]  TAG_DWELL    = 2'h1;
    localparam logic [1:0]  TAG_LEVEL    = 2'h2;
    localparam int          COPY_DIR_BIT = 0;
    localparam int          CTRL_STEP_BIT = 0;
    localparam int          ST_RUN_BIT   = 31;
    localparam int          ST_LOAD_BIT  = 30;
    localparam int          ST_COPY_BIT  = 29;

    typedef struct packed {
        logic [45:0] freq;
        logic [15:0] level;
        logic [31:0] dwell;
    } slc_point_t;

    // bit order matches the trigger register: [4:2] line, [1] backplane, [0] edge
    typedef struct packed {
        logic [2:0] line;
        logic       bpEnable;
        logic       risingEdge;
    } slc_trig_cfg_t;

    typedef enum logic {ST_IDLE, ST_RUN} slc_state_t;

endpackage

/* File: verification/slc_host_model.sv */
`timescale 1ns/100ps
module slc_host_model (
    input  wire logic        clock,           // system clock
    output logic      [7:0]  avs_address,     // byte address
    output logic             avs_read,        // read request
    output logic             avs_write,       // write request
    output logic      [31:0] avs_writedata,   // write data
    input  wire logic [31:0] avs_readdata,    // read data
    input  wire logic        avs_waitrequest  // stall
);
    int busTimeouts = 0;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // ------------------------------------------------------------
    // one bus access, held until waitrequest is seen low or 5000 cycles pass
    // ------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= {idx, 2'h0};
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 5000);
        q = avs_readdata;
        if (n >= 5000) busTimeouts++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // high half first, low half commits the word
    task automatic load_word(input logic [47:0] w);
        logic [31:0] q;
        xfer(1'b0, slc_pkg::IDX_LOAD_HI, {16'h0, w[47:32]}, q);
        xfer(1'b0, slc_pkg::IDX_LOAD_LO, w[31:0], q);
    endtask
    task automatic load_point(input logic [45:0] f, input logic [15:0] l, input logic [31:0] w);
        load_word({slc_pkg::TAG_FREQ, f});
        load_word({slc_pkg::TAG_LEVEL, 30'h0, l});
        load_word({slc_pkg::TAG_DWELL, 14'h0, w});
    endtask
    task automatic kick;
        logic [31:0] q;
        xfer(1'b0, slc_pkg::IDX_KICK, 32'h0, q);
    endtask
endmodule

/* File: verification/sweep_list_control_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sweep_list_control_regs_tb;
    typedef struct packed {
        logic [7:0]  hi;
        logic [31:0] lo;
        logic [39:0] want;
    } slc_row_t;
    const slc_row_t rows [3] = '{'{8'h12, 32'h3456789A, 40'h123456789A},
        '{8'hFF, 32'h00000000, 40'hFF00000000}, '{8'h00, 32'hFFFFFFFF, 40'h00FFFFFFFF}};
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        extTrig = 1'b1;
    logic [7:0]  bpTrig = 8'h00;
    logic        backplaneFitted = 1'b1;
    logic [7:0]  avsAddress;
    logic        avsRead, avsWrite, avsWaitrequest, sweepActive;
    logic [31:0] avsWritedata, avsReaddata, d;
    logic [39:0] outFreq;
    logic [15:0] outLevel;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n;
    always #5 clock = ~clock;
    slc_list_regs #(.HALF_MS_CYC(4)) u_dut (.clock(clock), .rstn(rstn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .extTrig(extTrig), .bpTrig(bpTrig),
        .backplaneFitted(backplaneFitted), .outFreq(outFreq), .outLevel(outLevel), .sweepActive(sweepActive));
    slc_host_model u_host (.clock(clock), .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));
    task automatic wr(input logic [5:0] idx, input logic [31:0] v);
        u_host.xfer(1'b0, idx, v, d);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask
    // wait up to 200 cycles for the engine to stop, n holds the cycles spent
    task automatic wait_stop;
        n = 0;
        while (sweepActive !== 1'b0 && n < 200) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a bus wait that ran out ends the run at once
    always @(posedge clock) begin
        if (u_host.busTimeouts != 0) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        cyc(12);
        `CHK({avsWaitrequest, sweepActive, outFreq}, {1'b1, 1'b0, 40'h0})
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wr(slc_pkg::IDX_FREQ_HI, {24'h0, rows[i].hi});
            wr(slc_pkg::IDX_FREQ_LO, rows[i].lo);
            cyc(1);
            `CHK(outFreq, rows[i].want)
        end
        u_host.xfer(1'b1, slc_pkg::IDX_REPEAT, 32'h0, d);
        `CHK(d, 32'h0)
        u_host.xfer(1'b1, 6'h30, 32'h0, d);
        `CHK(d, 32'h0)
        // ------------------------------------------------------------
        // list load with a stray dwell word, then step mode
        // ------------------------------------------------------------
        u_host.load_word(slc_pkg::LOADER_START);
        u_host.load_word({slc_pkg::TAG_DWELL, 46'h5});
        u_host.load_point(46'h0000_1234_5678, 16'h8123, 32'h1);
        u_host.load_point(46'h00AB_CDEF_0123, 16'h0456, 32'h1);
        u_host.load_word(slc_pkg::LOADER_END);
        wr(slc_pkg::IDX_CTRL, 32'h1);
        extTrig <= 1'b0;
        cyc(3);
        `CHK({sweepActive, outFreq, outLevel}, {1'b1, 40'h0012345678, 16'h8123})
        wr(slc_pkg::IDX_TRIG, 32'h17);
        bpTrig <= 8'h10;
        cyc(3);
        `CHK(outFreq, 40'h0012345678)
        bpTrig <= 8'h30;
        cyc(3);
        `CHK({outFreq, outLevel}, {40'hABCDEF0123, 16'h0456})
        backplaneFitted <= 1'b0;
        bpTrig <= 8'h00;
        cyc(3);
        bpTrig <= 8'h20;
        cyc(3);
        `CHK(outFreq, 40'hABCDEF0123)
        u_host.kick();
        cyc(3);
        `CHK(sweepActive, 1'b0)
        // ------------------------------------------------------------
        // start/stop: counted, shortened, endless
        // ------------------------------------------------------------
        wr(slc_pkg::IDX_CTRL, 32'h0);
        wr(slc_pkg::IDX_REPEAT, 32'h1);
        u_host.kick();
        cyc(3);
        `CHK(sweepActive, 1'b1)
        wait_stop();
        `CHK(n, 6)
        wr(slc_pkg::IDX_TOTAL, 32'h1);
        u_host.kick();
        cyc(1);
        wait_stop();
        `CHK(n, 4)
        wr(slc_pkg::IDX_COPY, 32'h0);
        wr(slc_pkg::IDX_TOTAL, 32'h2);
        wr(slc_pkg::IDX_COPY, 32'h0);
        u_host.load_word(slc_pkg::LOADER_START);
        u_host.load_point(46'h0000_0000_0777, 16'h0001, 32'h1);
        u_host.load_word(slc_pkg::LOADER_END);
        wr(slc_pkg::IDX_COPY, 32'h1);
        wr(slc_pkg::IDX_REPEAT, 32'h0);
        u_host.kick();
        cyc(60);
        `CHK({sweepActive, outFreq}, {1'b1, 40'h0012345678})
        u_host.kick();
        cyc(3);
        `CHK(sweepActive, 1'b0)
        u_host.kick();
        cyc(5);
        rstn <= 1'b0;
        cyc(2);
        `CHK({avsWaitrequest, sweepActive, outFreq, outLevel}, {1'b1, 1'b0, 40'h0, 16'h0})
        rstn <= 1'b1;
        u_host.xfer(1'b1, slc_pkg::IDX_STATUS, 32'h0, d);
        `CHK(d, 32'h0)
        `CHK(u_host.busTimeouts, 0)
        tally_and_finish();
    end
endmodule
